// File: rtl/wgs_status_words.sv
// Read-only bank of process-data status words sent from the web guide to the PLC.
`timescale 1ns/1ps

// Functional notes
// - Coverage is the sum of web widths seen in one captured line.
// - Coverage counts web pixels, so gaps equal pixel count minus coverage.
// - Coverage is raw per line; the filter setting never touches it.
// - Quality word: sensor one in high byte, sensor two in low byte.
// - Status bits 0..6 report panel, driver, fault, disturbance, traction, misalign, extreme.
// - Status bit 7 is low while a high-frequency disturbance is present.
// - Status bits 8..12 report auto, jog left, jog right, centering, good guiding.
// - Guide point word is the current signed offset, local or remote.
// - Word 7 high byte is actuator speed percent, 0 to 100.
// - Word 7 low byte is actuator acceleration percent, 0 to 100.
// - Each sensor has a word with its count of separate threads.
// - Actuator information appears only while the PLC page select equals 1.
// - Pitch is 8 bits at 0.25 mm; stroke is 7 bits at 5 mm.
// - Page words carry bits 15 and 14 set; zero means page rejected.
// - Position byte is 0..100 normal polarity, 128..228 reversed.
// - Bit 13 motor polarity, bit 12 servo-center polarity, 1 meaning normal.
// - Normal polarity extends on jog right; reversed polarity swaps directions.
// - Bits 11..9 show lock, limits, centering enables; bit 8 error polarity.
// - In width mode words 14 and 15 form one 32-bit count, upper first.
// - Width includes taught compensation and is valid only after teaching.
// - With the filter on, width mode reports the filtered width.
// - Outside width mode words 14 and 15 are raw per-sensor mean widths.
module wgs_status_words #(
	parameter int NUM_SENSORS = 2                  // Sensors feeding the bank.
) (
	input  wire logic                   i_ref_clk,        // 100 MHz clock.
	input  wire logic                   i_rst_n,          // Asynchronous reset, active low.
	// PLC side of the image.
	input  wire logic [3:0]             i_rd_idx,         // Word index being read.
	input  wire logic [7:0]             i_page_sel,       // Page number from PLC command word.
	output logic [15:0]                 o_rd_data,        // Word contents, one cycle later.
	// Sensor pixel streams, one lane per sensor.
	input  wire logic [NUM_SENSORS-1:0] i_pix_valid,      // Pixel present this cycle.
	input  wire logic [NUM_SENSORS-1:0] i_pix_web,        // Pixel is covered by web.
	input  wire logic [NUM_SENSORS-1:0] i_pix_first,      // First pixel of a line.
	input  wire logic [NUM_SENSORS-1:0] i_pix_last,       // Last pixel of a line.
	input  wire logic [7:0]             i_quality_s1,     // Sensor one quality factor.
	input  wire logic [7:0]             i_quality_s2,     // Sensor two quality factor.
	// Guide state.
	input  wire logic [6:0]             i_guide_flags,    // Panel, driver, fault and alarms.
	input  wire logic                   i_hf_disturb,     // High-frequency disturbance seen.
	input  wire logic [4:0]             i_guide_mode,     // Auto, jogs, centering, good.
	input  wire logic [15:0]            i_guide_point,    // Signed guide point offset.
	input  wire logic [6:0]             i_speed_pct,      // Actuator speed percent.
	input  wire logic [6:0]             i_accel_pct,      // Actuator acceleration percent.
	// Actuator settings.
	input  wire logic [7:0]             i_act_pitch,      // Pitch in 0.25 mm counts.
	input  wire logic [6:0]             i_act_stroke,     // Stroke in 5 mm counts.
	input  wire logic [6:0]             i_act_pos_pct,    // Actuator position percent.
	input  wire logic                   i_motor_pol_norm, // Motor polarity normal.
	input  wire logic                   i_sc_pol_norm,    // Servo-center polarity normal.
	input  wire logic                   i_lock_lost_en,   // Lock on lost edge enabled.
	input  wire logic                   i_limit_en,       // Limit switches enabled.
	input  wire logic                   i_sc_en,          // Servo centering enabled.
	input  wire logic                   i_err_pol_rev,    // Error polarity reversed.
	// Width measurement.
	input  wire logic                   i_width_mode,     // Report width instead of means.
	input  wire logic                   i_width_taught,   // Nominal width has been taught.
	input  wire logic                   i_filter_en,      // Measurement filter enabled.
	input  wire logic [31:0]            i_width_raw,      // Raw width in pixels.
	input  wire logic [31:0]            i_width_filt,     // Filtered width in pixels.
	input  wire logic [31:0]            i_width_comp,     // Taught compensation in pixels.
	// Actuator drive.
	output logic                        o_act_extend,     // Drive actuator outward.
	output logic                        o_act_retract     // Drive actuator inward.
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		wgs_pkg::wgs_sns_t [NUM_SENSORS-1:0] sns;
		logic [31:0]                         width;
		logic [15:0]                         rd_data;
		logic                                extend;
		logic                                retract;
	} wgs_state_t;

	wgs_state_t state_q;
	wgs_state_t state_d;

	// Combinational views shared by the read mux.
	logic        page_ok;
	logic [15:0] stat_word;
	logic [15:0] ctrl_word;
	logic [7:0]  pos_byte;
	logic [31:0] width_src;

	// ------------------------------------------------------------------
	// Word assembly
	// ------------------------------------------------------------------

	// Page match gates every page-selected word.
	assign page_ok = (i_page_sel == wgs_pkg::PAGE_ACTUATOR);

	// Guide status word; bit 7 uses inverted sense and the top bits stay zero.
	assign stat_word = {3'h0,
	                    i_guide_mode,
	                    ~i_hf_disturb,
	                    i_guide_flags};

	// Position byte is shifted up by the reversed offset when polarity is reversed.
	assign pos_byte = i_motor_pol_norm ? {1'b0, i_act_pos_pct}
	                                   : (wgs_pkg::POS_REVERSED_OFS | {1'b0, i_act_pos_pct});

	// Controller and actuator word with its verification bits.
	always_comb begin
		ctrl_word = {wgs_pkg::PAGE_VERIFY, 14'h0000};
		ctrl_word[wgs_pkg::CTRL_MOTOR_POL_BIT] = i_motor_pol_norm;
		ctrl_word[wgs_pkg::CTRL_SC_POL_BIT]    = i_sc_pol_norm;
		ctrl_word[wgs_pkg::CTRL_LOCK_BIT]      = i_lock_lost_en;
		ctrl_word[wgs_pkg::CTRL_LIMIT_BIT]     = i_limit_en;
		ctrl_word[wgs_pkg::CTRL_SC_EN_BIT]     = i_sc_en;
		ctrl_word[wgs_pkg::CTRL_ERR_POL_BIT]   = i_err_pol_rev;
		ctrl_word[7:0]                         = pos_byte;
	end

	// Filtered or raw width is chosen before the compensation is added.
	assign width_src = i_filter_en ? i_width_filt : i_width_raw;

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------

	// Scans each sensor line, divides for the mean width and builds the read word.
	always_comb begin
		logic [15:0] base_cov;
		logic [15:0] base_thr;
		logic [15:0] new_cov;
		logic [15:0] new_thr;
		logic        rise;
		logic [16:0] trial;
		base_cov = 16'h0000;
		base_thr = 16'h0000;
		new_cov  = 16'h0000;
		new_thr  = 16'h0000;
		rise     = 1'b0;
		trial    = 17'h00000;
		state_d  = state_q;

		for (int s = 0; s < NUM_SENSORS; s++) begin
			// Line scanner: web pixels sum the widths, rising edges count threads.
			if (i_pix_valid[s]) begin
				base_cov = i_pix_first[s] ? 16'h0000 : state_q.sns[s].acc_cov;
				base_thr = i_pix_first[s] ? 16'h0000 : state_q.sns[s].acc_thr;
				rise     = i_pix_web[s] && (i_pix_first[s] || !state_q.sns[s].prev);
				new_cov  = base_cov + {15'h0000, i_pix_web[s]};
				new_thr  = base_thr + {15'h0000, rise};
				state_d.sns[s].acc_cov = new_cov;
				state_d.sns[s].acc_thr = new_thr;
				state_d.sns[s].prev    = i_pix_web[s];
				if (i_pix_last[s]) begin
					// Raw per-line result, never passed through the filter.
					state_d.sns[s].cov = new_cov;
					state_d.sns[s].thr = new_thr;
					// A new line restarts the divider for the mean width.
					state_d.sns[s].quo = new_cov;
					state_d.sns[s].dvs = new_thr;
					state_d.sns[s].rem = 17'h00000;
					state_d.sns[s].cnt = 5'h00;
					state_d.sns[s].div = wgs_pkg::DIV_RUN;
				end
			end

			// Restoring divider, one quotient bit per cycle; a line end restarts it.
			if (!(i_pix_valid[s] && i_pix_last[s])) begin
				case (state_q.sns[s].div)
					wgs_pkg::DIV_IDLE: begin
						state_d.sns[s].div = wgs_pkg::DIV_IDLE;
					end
					wgs_pkg::DIV_RUN: begin
						if (state_q.sns[s].dvs == 16'h0000) begin
							// No threads seen: the mean is reported as zero.
							state_d.sns[s].mean = 16'h0000;
							state_d.sns[s].div  = wgs_pkg::DIV_IDLE;
						end else begin
							trial = {state_q.sns[s].rem[15:0], state_q.sns[s].quo[15]};
							state_d.sns[s].quo = {state_q.sns[s].quo[14:0], 1'b0};
							if (trial >= {1'b0, state_q.sns[s].dvs}) begin
								state_d.sns[s].rem    = trial - {1'b0, state_q.sns[s].dvs};
								state_d.sns[s].quo[0] = 1'b1;
							end else begin
								state_d.sns[s].rem = trial;
							end
							state_d.sns[s].cnt = state_q.sns[s].cnt + 5'h01;
							if (state_q.sns[s].cnt == wgs_pkg::DIV_STEPS - 5'h01) begin
								// Last step: publish the mean width.
								state_d.sns[s].mean = trial >= {1'b0, state_q.sns[s].dvs}
								                    ? {state_q.sns[s].quo[14:0], 1'b1}
								                    : {state_q.sns[s].quo[14:0], 1'b0};
								state_d.sns[s].div  = wgs_pkg::DIV_IDLE;
							end
						end
					end
					default: begin
						state_d.sns[s].div = wgs_pkg::DIV_IDLE;
					end
				endcase
			end
		end

		// Taught width with compensation; zero until a nominal width is taught.
		state_d.width = i_width_taught ? (width_src + i_width_comp) : 32'h00000000;

		// Jog direction follows motor polarity.
		state_d.extend  = i_motor_pol_norm ? i_guide_mode[2] : i_guide_mode[1];
		state_d.retract = i_motor_pol_norm ? i_guide_mode[1] : i_guide_mode[2];

		// Read multiplexer; unlisted words read as zero.
		case (i_rd_idx)
			wgs_pkg::WORD_GUIDE_STATUS: begin
				state_d.rd_data = stat_word;
			end
			wgs_pkg::WORD_GUIDE_POINT: begin
				state_d.rd_data = i_guide_point;
			end
			wgs_pkg::WORD_COVERAGE_S1: begin
				state_d.rd_data = state_q.sns[0].cov;
			end
			wgs_pkg::WORD_COVERAGE_S2: begin
				state_d.rd_data = state_q.sns[NUM_SENSORS-1].cov;
			end
			wgs_pkg::WORD_QUALITY: begin
				state_d.rd_data = {i_quality_s1, i_quality_s2};
			end
			wgs_pkg::WORD_SPEED_ACCEL: begin
				state_d.rd_data = {1'b0, i_speed_pct, 1'b0, i_accel_pct};
			end
			wgs_pkg::WORD_THREADS_S1: begin
				state_d.rd_data = state_q.sns[0].thr;
			end
			wgs_pkg::WORD_THREADS_S2: begin
				state_d.rd_data = state_q.sns[NUM_SENSORS-1].thr;
			end
			wgs_pkg::WORD_ACT_STROKE: begin
				state_d.rd_data = page_ok ? {wgs_pkg::PAGE_VERIFY, 7'h00, i_act_stroke}
				                          : wgs_pkg::WORD_RESET;
			end
			wgs_pkg::WORD_ACT_INFO: begin
				state_d.rd_data = page_ok ? {wgs_pkg::PAGE_VERIFY, 6'h00, i_act_pitch}
				                          : wgs_pkg::WORD_RESET;
			end
			wgs_pkg::WORD_CTRL_ACT: begin
				state_d.rd_data = page_ok ? ctrl_word : wgs_pkg::WORD_RESET;
			end
			wgs_pkg::WORD_WIDTH_UPPER: begin
				state_d.rd_data = i_width_mode ? state_q.width[31:16]
				                               : state_q.sns[0].mean;
			end
			wgs_pkg::WORD_WIDTH_LOWER: begin
				state_d.rd_data = i_width_mode ? state_q.width[15:0]
				                               : state_q.sns[NUM_SENSORS-1].mean;
			end
			default: begin
				state_d.rd_data = wgs_pkg::WORD_RESET;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------

	// All state clears to zero under reset.
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	// Outputs come straight from the state register.
	assign o_rd_data     = state_q.rd_data;
	assign o_act_extend  = state_q.extend;
	assign o_act_retract = state_q.retract;

endmodule // wgs_status_words

// File: pkg/wgs_pkg.sv
// Package of word indexes, field positions and types for the web guide status word bank.
package wgs_pkg;

	// ------------------------------------------------------------------
	// Word indexes of the process-data image read by the PLC
	// ------------------------------------------------------------------
	localparam logic [3:0] WORD_GUIDE_STATUS   = 4'h2;
	localparam logic [3:0] WORD_GUIDE_POINT    = 4'h3;
	localparam logic [3:0] WORD_COVERAGE_S1    = 4'h4;
	localparam logic [3:0] WORD_COVERAGE_S2    = 4'h5;
	localparam logic [3:0] WORD_QUALITY        = 4'h6;
	localparam logic [3:0] WORD_SPEED_ACCEL    = 4'h7;
	localparam logic [3:0] WORD_THREADS_S1     = 4'h8;
	localparam logic [3:0] WORD_THREADS_S2     = 4'h9;
	localparam logic [3:0] WORD_ACT_STROKE     = 4'hb;
	localparam logic [3:0] WORD_ACT_INFO       = 4'hc;
	localparam logic [3:0] WORD_CTRL_ACT       = 4'hd;
	localparam logic [3:0] WORD_WIDTH_UPPER    = 4'he;
	localparam logic [3:0] WORD_WIDTH_LOWER    = 4'hf;

	// ------------------------------------------------------------------
	// Field positions and fixed values
	// ------------------------------------------------------------------
	localparam int         STAT_HF_CLEAR_BIT   = 7;
	localparam int         STAT_MODE_LSB       = 8;
	localparam int         CTRL_MOTOR_POL_BIT  = 13;
	localparam int         CTRL_SC_POL_BIT     = 12;
	localparam int         CTRL_LOCK_BIT       = 11;
	localparam int         CTRL_LIMIT_BIT      = 10;
	localparam int         CTRL_SC_EN_BIT      = 9;
	localparam int         CTRL_ERR_POL_BIT    = 8;
	localparam logic [1:0] PAGE_VERIFY         = 2'h3;
	localparam logic [7:0] PAGE_ACTUATOR       = 8'h01;
	localparam logic [7:0] POS_REVERSED_OFS    = 8'h80;
	localparam logic [15:0] WORD_RESET         = 16'h0000;
	localparam logic [4:0] DIV_STEPS           = 5'h10;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [0:0] {
		DIV_IDLE = 1'b0,
		DIV_RUN  = 1'b1
	} wgs_div_state_t;

	// Per-sensor line scanner and mean-width divider state.
	typedef struct packed {
		logic [15:0]    acc_cov;
		logic [15:0]    acc_thr;
		logic           prev;
		logic [15:0]    cov;
		logic [15:0]    thr;
		logic [15:0]    mean;
		logic [15:0]    quo;
		logic [16:0]    rem;
		logic [15:0]    dvs;
		logic [4:0]     cnt;
		wgs_div_state_t div;
	} wgs_sns_t;

endpackage

// File: verification/wgs_status_words_props.sv
// Assertions on the read port and jog outputs of the status word bank.
`timescale 1ns/1ps
module wgs_status_words_props (
	input  wire logic        i_ref_clk,        // Clock.
	input  wire logic        i_rst_n,          // Reset, active low.
	input  wire logic [3:0]  i_rd_idx,         // Word index.
	input  wire logic [7:0]  i_page_sel,       // Page number.
	input  wire logic [15:0] o_rd_data,        // Word contents.
	input  wire logic [7:0]  i_quality_s1,     // Quality one.
	input  wire logic [7:0]  i_quality_s2,     // Quality two.
	input  wire logic [6:0]  i_guide_flags,    // Status flags.
	input  wire logic        i_hf_disturb,     // Disturbance.
	input  wire logic [4:0]  i_guide_mode,     // Mode bits.
	input  wire logic [15:0] i_guide_point,    // Guide point.
	input  wire logic [6:0]  i_speed_pct,      // Speed.
	input  wire logic [6:0]  i_accel_pct,      // Acceleration.
	input  wire logic [7:0]  i_act_pitch,      // Pitch.
	input  wire logic [6:0]  i_act_pos_pct,    // Position.
	input  wire logic        i_motor_pol_norm, // Motor polarity.
	input  wire logic        o_act_extend,     // Extend drive.
	input  wire logic        o_act_retract     // Retract drive.
);
	// ------------------------------------------------------------------
	// Clocking and helpers
	// ------------------------------------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	// Expected extend and retract pair for the present jog and polarity.
	wire logic [1:0] jog_drive = i_motor_pol_norm ? i_guide_mode[2:1] :
		{i_guide_mode[1], i_guide_mode[2]};

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	chk_status_flags: assert property (i_rd_idx == 4'h2 |=> o_rd_data[6:0] == $past(i_guide_flags))
		else $error("status flags wrong");
	chk_hf_inverted: assert property (i_rd_idx == 4'h2 |=> o_rd_data[7] == !$past(i_hf_disturb))
		else $error("disturbance bit not inverted");
	chk_status_mode: assert property (i_rd_idx == 4'h2 |=>
		o_rd_data[15:8] == {3'h0, $past(i_guide_mode)}) else $error("mode bits wrong");
	chk_guide_point: assert property (i_rd_idx == 4'h3 |=> o_rd_data == $past(i_guide_point))
		else $error("guide point wrong");
	chk_quality_bytes: assert property (i_rd_idx == 4'h6 |=>
		o_rd_data == {$past(i_quality_s1), $past(i_quality_s2)}) else $error("quality wrong");
	chk_speed_accel: assert property (i_rd_idx == 4'h7 |=>
		o_rd_data == {1'b0, $past(i_speed_pct), 1'b0, $past(i_accel_pct)})
		else $error("speed word wrong");
	chk_page_refused: assert property (i_rd_idx inside {4'hb, 4'hc, 4'hd} &&
		i_page_sel != 8'h01 |=> o_rd_data == 16'h0000) else $error("page word not blank");
	chk_pitch_page: assert property (i_rd_idx == 4'hc && i_page_sel == 8'h01 |=>
		o_rd_data == {2'h3, 6'h00, $past(i_act_pitch)}) else $error("pitch word wrong");
	chk_position_byte: assert property (i_rd_idx == 4'hd && i_page_sel == 8'h01 |=>
		o_rd_data[15:13] == {2'h3, $past(i_motor_pol_norm)} &&
		o_rd_data[7:0] == {!$past(i_motor_pol_norm), $past(i_act_pos_pct)})
		else $error("position word wrong");
	chk_jog_direction: assert property ($past(i_rst_n) |->
		{o_act_extend, o_act_retract} == $past(jog_drive)) else $error("jog direction wrong");
endmodule // wgs_status_words_props

bind wgs_status_words wgs_status_words_props u_wgs_status_words_props (
	.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_rd_idx(i_rd_idx), .i_page_sel(i_page_sel),
	.o_rd_data(o_rd_data), .i_quality_s1(i_quality_s1), .i_quality_s2(i_quality_s2),
	.i_guide_flags(i_guide_flags), .i_hf_disturb(i_hf_disturb), .i_guide_mode(i_guide_mode),
	.i_guide_point(i_guide_point), .i_speed_pct(i_speed_pct), .i_accel_pct(i_accel_pct),
	.i_act_pitch(i_act_pitch), .i_act_pos_pct(i_act_pos_pct),
	.i_motor_pol_norm(i_motor_pol_norm), .o_act_extend(o_act_extend),
	.o_act_retract(o_act_retract));

// File: verification/wgs_plc_model.sv
// Behavioural PLC that reads words from the status bank.
`timescale 1ns/1ps
module wgs_plc_model (
	input  wire logic        i_ref_clk,  // Clock.
	input  wire logic [15:0] i_rd_data,  // Word from the bank.
	output logic [3:0]       o_rd_idx,   // Word index asked for.
	output logic [7:0]       o_page_sel  // Page number from the command image.
);
	// Index and page start at zero so nothing is unknown before reset ends.
	initial begin
		o_rd_idx = 4'h0;
		o_page_sel = 8'h00;
	end
	// Presents index and page after an edge and takes the word two edges later.
	task automatic read_word(input logic [3:0] idx, input logic [7:0] pg, output logic [15:0] d);
		@(posedge i_ref_clk);
		o_rd_idx <= idx;
		o_page_sel <= pg;
		repeat (2) @(posedge i_ref_clk);
		d = i_rd_data;
	endtask
endmodule // wgs_plc_model

// File: verification/wgs_status_words_tb_top.sv
// Self-checking testbench of the web guide status word bank.
`timescale 1ns/1ps
module wgs_status_words_tb_top;
	logic        i_ref_clk, i_rst_n, i_hf_disturb, i_motor_pol_norm, i_sc_pol_norm;
	logic        i_lock_lost_en, i_limit_en, i_sc_en, i_err_pol_rev, o_act_extend;
	logic        o_act_retract, i_width_mode, i_width_taught, i_filter_en;
	logic [1:0]  i_pix_valid, i_pix_web, i_pix_first, i_pix_last;
	logic [3:0]  i_rd_idx;
	logic [7:0]  i_page_sel, i_quality_s1, i_quality_s2, i_act_pitch;
	logic [6:0]  i_guide_flags, i_speed_pct, i_accel_pct, i_act_stroke, i_act_pos_pct;
	logic [4:0]  i_guide_mode;
	logic [15:0] o_rd_data, i_guide_point, got;
	logic [31:0] i_width_raw, i_width_filt, i_width_comp;
	int          n_mismatch, samples_checked;

	// The bank under test and the PLC reading it.
	wgs_status_words u_wgs_status_words (.i_ref_clk, .i_rst_n, .i_rd_idx, .i_page_sel,
		.o_rd_data, .i_pix_valid, .i_pix_web, .i_pix_first, .i_pix_last, .i_quality_s1,
		.i_quality_s2, .i_guide_flags, .i_hf_disturb, .i_guide_mode, .i_guide_point,
		.i_speed_pct, .i_accel_pct, .i_act_pitch, .i_act_stroke, .i_act_pos_pct,
		.i_motor_pol_norm, .i_sc_pol_norm, .i_lock_lost_en, .i_limit_en, .i_sc_en,
		.i_err_pol_rev, .i_width_mode, .i_width_taught, .i_filter_en, .i_width_raw,
		.i_width_filt, .i_width_comp, .o_act_extend, .o_act_retract);
	wgs_plc_model u_wgs_plc_model (.i_ref_clk, .i_rd_data(o_rd_data), .o_rd_idx(i_rd_idx),
		.o_page_sel(i_page_sel));

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	// Counts a comparison and reports a mismatch at once.
	task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// Reads one word through the PLC model and compares it.
	task automatic rd_chk(input logic [3:0] i, input logic [7:0] p, input logic [15:0] e);
		u_wgs_plc_model.read_word(i, p, got);
		chk_word(got, e);
	endtask
	// Feeds one line of n pixels on both lanes; bit k of a pattern is pixel k.
	task automatic feed(input logic [7:0] a, input logic [7:0] b, input int n);
		for (int k = 0; k < n; k++) begin
			@(posedge i_ref_clk);
			i_pix_valid <= 2'h3;
			i_pix_web <= {b[k], a[k]};
			i_pix_first <= {2{k == 0}};
			i_pix_last <= {2{k == n - 1}};
		end
		@(posedge i_ref_clk);
		i_pix_valid <= 2'h0;
	endtask
	// Sets a jog and polarity, then checks the drive pair two edges on.
	task automatic jog(input logic m, input logic [4:0] md, input logic [15:0] e);
		@(posedge i_ref_clk);
		i_motor_pol_norm <= m;
		i_guide_mode <= md;
		repeat (2) @(posedge i_ref_clk);
		chk_word({14'h0000, o_act_extend, o_act_retract}, e);
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ------------------------------------------------------------------
	// Clock, watchdog and main sequence
	// ------------------------------------------------------------------
	// Free-running 100 MHz clock.
	initial begin
		i_ref_clk = 1'b0;
		forever #5 i_ref_clk = ~i_ref_clk;
	end
	// Cuts a hang short.
	initial begin
		repeat (5000) @(posedge i_ref_clk);
		n_mismatch++;
		close_out();
	end
	// Drives every input from time zero and walks through the words.
	initial begin
		{i_rst_n, i_pix_valid, i_pix_web, i_pix_first, i_pix_last, i_hf_disturb} = '0;
		{i_motor_pol_norm, i_sc_pol_norm, i_lock_lost_en, i_limit_en, i_sc_en} = '0;
		{i_err_pol_rev, i_width_mode, i_width_taught, i_filter_en, i_guide_mode} = '0;
		{i_quality_s1, i_quality_s2, i_act_pitch, i_guide_flags, i_speed_pct} = '0;
		{i_accel_pct, i_act_stroke, i_act_pos_pct, i_guide_point} = '0;
		{i_width_raw, i_width_filt, i_width_comp, n_mismatch, samples_checked} = '0;
		repeat (4) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		rd_chk(4'h0, 8'h01, 16'h0000);
		rd_chk(4'ha, 8'h01, 16'h0000);
		i_guide_flags <= 7'h55;
		i_hf_disturb <= 1'b1;
		i_guide_mode <= 5'h15;
		{i_quality_s1, i_quality_s2, i_guide_point} <= {8'hc8, 8'h03, 16'h8001};
		{i_speed_pct, i_accel_pct} <= {7'h64, 7'h00};
		rd_chk(4'h2, 8'h00, 16'h1555);
		rd_chk(4'h6, 8'h00, 16'hc803);
		rd_chk(4'h3, 8'h00, 16'h8001);
		rd_chk(4'h7, 8'h00, 16'h6400);
		{i_guide_flags, i_hf_disturb, i_guide_mode} <= {7'h2a, 1'b0, 5'h0a};
		{i_speed_pct, i_accel_pct} <= {7'h00, 7'h64};
		rd_chk(4'h2, 8'h00, 16'h0aaa);
		rd_chk(4'h7, 8'h00, 16'h0064);
		{i_act_pitch, i_act_stroke, i_act_pos_pct, i_motor_pol_norm} <= {8'hff, 7'h7f, 7'h64, 1'b1};
		{i_sc_pol_norm, i_lock_lost_en, i_limit_en, i_sc_en, i_err_pol_rev} <= 5'h15;
		for (int i = 0; i < 6; i++) rd_chk(4'(11 + i % 3), 8'(i / 3 * 2), 16'h0000);
		rd_chk(4'hc, 8'h01, 16'hc0ff);
		rd_chk(4'hb, 8'h01, 16'hc07f);
		rd_chk(4'hd, 8'h01, 16'hf564);
		{i_act_pos_pct, i_motor_pol_norm} <= {7'h00, 1'b0};
		{i_sc_pol_norm, i_lock_lost_en, i_limit_en, i_sc_en, i_err_pol_rev} <= 5'h0a;
		rd_chk(4'hd, 8'h01, 16'hca80);
		jog(1'b1, 5'h04, 16'h0002);
		jog(1'b1, 5'h02, 16'h0001);
		jog(1'b0, 5'h04, 16'h0001);
		jog(1'b0, 5'h02, 16'h0002);
		feed(8'h0b, 8'h3a, 7);
		rd_chk(4'h4, 8'h01, 16'h0003);
		rd_chk(4'h5, 8'h01, 16'h0004);
		chk_word(16'h0007 - got, 16'h0003);
		rd_chk(4'h8, 8'h01, 16'h0002);
		rd_chk(4'h9, 8'h01, 16'h0002);
		i_filter_en <= 1'b1;
		rd_chk(4'h4, 8'h01, 16'h0003);
		repeat (17) @(posedge i_ref_clk);
		rd_chk(4'he, 8'h01, 16'h0001);
		rd_chk(4'hf, 8'h01, 16'h0002);
		{i_width_raw, i_width_filt, i_width_comp} <= {32'h0001fffe, 32'h12345678, 32'h00000003};
		{i_width_mode, i_filter_en} <= 2'h2;
		rd_chk(4'he, 8'h01, 16'h0000);
		i_width_taught <= 1'b1;
		rd_chk(4'he, 8'h01, 16'h0002);
		rd_chk(4'hf, 8'h01, 16'h0001);
		i_filter_en <= 1'b1;
		rd_chk(4'he, 8'h01, 16'h1234);
		rd_chk(4'hf, 8'h01, 16'h567b);
		close_out();
	end
endmodule // wgs_status_words_tb_top
